// *** hw/dpbc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - 32K direct mode: initiator pin becomes A14; 64K: responder pin becomes A15
// - Multiplexed mode drives high byte on A0-A7 and strobes a latch on A8 or A9 in the same cycle
// - Latch update follows high-byte increment without port A, or processor write
// - Streaming refreshes an external latch every 256 bytes
// - Peripheral cycles beat host cycles and latch updates
// - Reset bit holds all registers reset; any write clears pointers
// - Masked stop compare halts host cycles and sets done
// - Writing high stop byte resumes host cycles if still armed
// - Host data decode pulses latch-out; buffer decode drives select and write
// - Arbitration waits for free bus, latches 2 to 3 clocks later
// - Busy and bus-out follow latch after four clocks or at once
// - Software bus enables ORed with hardware enables on pins
// - Live select and busy inputs readable; bits 6,7 drive select, busy
// - DMA bit1 reads acknowledge; bits 2,3 start host DMA per direction
// - Direction set: peripheral into buffer; clear: buffer to peripheral
// - Size register is a low-bit mask fixing ring wrap
// - Mode register resets to zero; bits select addressing, arbitration, strobe
// - Mode low bits 0,1,3,7 give 1K,16K,32K,64K; arbitration by bit xor
// - Size beyond direct range selects multiplexed addressing
// - Peripheral request sampled, transfer in the following cycle
// - Buffer-to-host: latch data, bus-out, request, release after acknowledge
// - DMA control bit 5 shows done
// - Processor buffer access uses direction pointer without incrementing
module dpbc_top (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_cs,
	input wire logic i_ale,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_ad,
	output logic [7:0] o_ad,
	output logic o_ad_oe_n,
	input wire logic i_porta_req_n,
	output logic o_portb_req,
	input wire logic i_portb_ack,
	input wire logic i_sel_in,
	input wire logic i_bus_occupied_in,
	output logic o_sel_out,
	output logic o_bus_occupied_out,
	output logic [15:0] o_addr,
	output logic o_memory_select_n,
	output logic o_we_n,
	output logic o_bus_in_enable_n,
	output logic o_bus_out_enable_n,
	output logic o_latch_out
);
	// ==========================================
	// Helpers
	function automatic logic [15:0] ptr_inc(input logic [15:0] p, input logic [7:0] sz);
		logic [15:0] m;
		m = {sz, dpbc_pkg::LOW_MAX};
		ptr_inc = ((p + dpbc_pkg::PTR_ONE) & m) | (p & ~m);
	endfunction

	function automatic logic ptr_eq(input logic [15:0] a, input logic [15:0] b,
		input logic [7:0] sz);
		ptr_eq = ((a ^ b) & {sz, dpbc_pkg::LOW_MAX}) == dpbc_pkg::PTR_RST;
	endfunction

	function automatic logic [7:0] range_hi(input logic [7:0] md);
		if (md[dpbc_pkg::MODE_A15]) begin
			range_hi = dpbc_pkg::RANGE_64K;
		end else if (md[dpbc_pkg::MODE_A14]) begin
			range_hi = dpbc_pkg::RANGE_32K;
		end else if (md[dpbc_pkg::MODE_EXT]) begin
			range_hi = dpbc_pkg::RANGE_16K;
		end else begin
			range_hi = dpbc_pkg::RANGE_1K;
		end
	endfunction

	function automatic logic [15:0] pin_addr(input logic [15:0] p, input logic mx,
		input logic [7:0] md, input logic [7:0] dm);
		logic [15:0] a;
		a = p;
		if (mx) begin
			a[dpbc_pkg::PIN_SHP] = 1'b0;
			a[dpbc_pkg::PIN_SDP] = 1'b0;
		end
		if (!md[dpbc_pkg::MODE_A14]) begin
			a[dpbc_pkg::PIN_EI] = ~dm[dpbc_pkg::DMA_EI];
		end
		if (!md[dpbc_pkg::MODE_A15]) begin
			a[dpbc_pkg::PIN_ET] = ~dm[dpbc_pkg::DMA_ET];
		end
		pin_addr = a;
	endfunction

	// ==========================================
	// Declarations
	logic [7:0] adr_q, hic_q, dma_q, size_q, mode_q;
	logic rst_q, wr_n_q, clr, ptr_clr, wr_go;
	logic [15:0] rp_q, wp_q, hp_q;
	logic pa_q, done_q, upd_rp_q, upd_wp_q;
	logic dir, mx, moe, armed, match, buf_acc;
	logic host_mem_go, host_inc, inc_rp, inc_wp, upd_rp_go, upd_wp_go;
	logic arb_bsy, hw_boe;
	logic [7:0] rdata;
	dpbc_pkg::dpbc_host_e hst_q;
	dpbc_pkg::dpbc_mem_s mem_d, mem_q;
	logic bsy_q, boe_q, bie_q;

	// ==========================================
	// Processor bus
	assign wr_go = i_cs && !i_wr_n && wr_n_q;
	assign clr = i_rst || rst_q;
	assign ptr_clr = clr || (wr_go && adr_q == dpbc_pkg::A_RST);

	// Address latch and write edge
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			adr_q <= dpbc_pkg::REG_RST;
			wr_n_q <= 1'b1;
		end else begin
			wr_n_q <= i_wr_n;
			if (i_ale) begin
				adr_q <= i_ad;
			end
		end
	end

	// Register reset bit, set by reset pin
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rst_q <= 1'b1;
		end else if (wr_go && adr_q == dpbc_pkg::A_RST) begin
			rst_q <= i_ad[dpbc_pkg::RST_BIT];
		end
	end

	// Control registers
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			hic_q <= dpbc_pkg::REG_RST;
			dma_q <= dpbc_pkg::REG_RST;
			size_q <= dpbc_pkg::REG_RST;
			mode_q <= dpbc_pkg::REG_RST;
		end else if (wr_go) begin
			if (adr_q == dpbc_pkg::A_HIC) begin
				hic_q <= i_ad & dpbc_pkg::HIC_WMASK;
			end
			if (adr_q == dpbc_pkg::A_DMA) begin
				dma_q <= i_ad & dpbc_pkg::DMA_WMASK;
			end
			if (adr_q == dpbc_pkg::A_SIZE) begin
				size_q <= i_ad;
			end
			if (adr_q == dpbc_pkg::A_MODE) begin
				mode_q <= i_ad;
			end
		end
	end

	// Readback mux
	always_comb begin
		rdata = dpbc_pkg::REG_RST;
		unique case (adr_q)
			dpbc_pkg::A_HIC: begin
				rdata = hic_q;
				rdata[dpbc_pkg::HIC_ARB] = bsy_q;
				rdata[dpbc_pkg::HIC_SEL_IN] = i_sel_in;
				rdata[dpbc_pkg::HIC_BUS_OCCUPIED_IN] = i_bus_occupied_in;
			end
			dpbc_pkg::A_DMA: begin
				rdata = dma_q;
				rdata[dpbc_pkg::DMA_ACK] = i_portb_ack;
				rdata[dpbc_pkg::DMA_DONE] = done_q;
			end
			dpbc_pkg::A_RP_LO: rdata = rp_q[7:0];
			dpbc_pkg::A_RP_HI: rdata = rp_q[15:8];
			dpbc_pkg::A_WP_LO: rdata = wp_q[7:0];
			dpbc_pkg::A_WP_HI: rdata = wp_q[15:8];
			dpbc_pkg::A_HP_LO: rdata = hp_q[7:0];
			dpbc_pkg::A_HP_HI: rdata = hp_q[15:8];
			default: rdata = dpbc_pkg::REG_RST;
		endcase
	end

	// Read data register and drive enable
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_ad <= dpbc_pkg::REG_RST;
		end else begin
			o_ad <= rdata;
		end
	end
	assign o_ad_oe_n = !(i_cs && !i_rd_n && adr_q >= dpbc_pkg::A_HIC
		&& adr_q <= dpbc_pkg::A_HP_HI);

	// ==========================================
	// Mode decode
	assign dir = dma_q[dpbc_pkg::DMA_DIR];
	assign moe = mode_q[dpbc_pkg::MODE_MOE];
	assign mx = |(size_q & ~range_hi(mode_q));
	assign armed = dir ? dma_q[dpbc_pkg::DMA_RD_LATCH] : dma_q[dpbc_pkg::DMA_WR_LATCH];
	assign match = ptr_eq(dir ? rp_q : wp_q, hp_q, size_q);
	assign buf_acc = i_cs && adr_q == dpbc_pkg::A_BUF && (!i_rd_n || !i_wr_n);

	// ==========================================
	// Port A sampling
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			pa_q <= 1'b0;
		end else begin
			pa_q <= !i_porta_req_n;
		end
	end

	// ==========================================
	// Buffer cycle scheduler, port A first
	always_comb begin
		mem_d.addr = pin_addr(dir ? wp_q : rp_q, mx, mode_q, dma_q);
		mem_d.sel_n = 1'b1;
		mem_d.we_n = 1'b1;
		mem_d.lo = wr_go && (adr_q == dpbc_pkg::A_HDATA || adr_q == dpbc_pkg::A_HDATA_HI);
		mem_d.bie = 1'b0;
		host_mem_go = 1'b0;
		upd_rp_go = 1'b0;
		upd_wp_go = 1'b0;
		if (pa_q) begin
			mem_d.sel_n = moe && dir;
			mem_d.we_n = !dir;
		end else if (mx && (upd_rp_q || upd_wp_q)) begin
			mem_d.addr[7:0] = upd_rp_q ? rp_q[15:8] : wp_q[15:8];
			mem_d.addr[dpbc_pkg::PIN_SHP] = upd_rp_q;
			mem_d.addr[dpbc_pkg::PIN_SDP] = !upd_rp_q;
			upd_rp_go = upd_rp_q;
			upd_wp_go = !upd_rp_q;
		end else if (hst_q == dpbc_pkg::H_MEM) begin
			host_mem_go = 1'b1;
			mem_d.addr = pin_addr(dir ? rp_q : wp_q, mx, mode_q, dma_q);
			mem_d.sel_n = moe && !dir;
			mem_d.we_n = dir;
			mem_d.lo = dir;
			mem_d.bie = !dir;
		end else if (buf_acc) begin
			mem_d.sel_n = moe && !i_wr_n;
			mem_d.we_n = i_wr_n;
		end
	end

	// Registered buffer-side outputs
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			mem_q.addr <= pin_addr(dpbc_pkg::PTR_RST, 1'b0, dpbc_pkg::REG_RST,
				dpbc_pkg::REG_RST);
			mem_q.sel_n <= 1'b1;
			mem_q.we_n <= 1'b1;
			mem_q.lo <= 1'b0;
			mem_q.bie <= 1'b0;
		end else begin
			mem_q <= mem_d;
		end
	end
	assign o_addr = mem_q.addr;
	assign o_memory_select_n = mem_q.sel_n;
	assign o_we_n = mem_q.we_n;
	assign o_latch_out = mem_q.lo;

	// ==========================================
	// Host DMA handshake
	assign host_inc = (hst_q == dpbc_pkg::H_REQ && i_portb_ack && dir) || (host_mem_go && !dir);
	assign hw_boe = hst_q == dpbc_pkg::H_REQ && dir;
	assign o_portb_req = hst_q == dpbc_pkg::H_REQ;

	always_ff @(posedge i_mclk) begin
		if (clr) begin
			hst_q <= dpbc_pkg::H_IDLE;
		end else begin
			unique case (hst_q)
				dpbc_pkg::H_IDLE: begin
					if (armed && !match && !done_q) begin
						hst_q <= dir ? dpbc_pkg::H_MEM : dpbc_pkg::H_REQ;
					end
				end
				dpbc_pkg::H_MEM: begin
					if (host_mem_go) begin
						hst_q <= dir ? dpbc_pkg::H_REQ : dpbc_pkg::H_REL;
					end
				end
				dpbc_pkg::H_REQ: begin
					if (i_portb_ack) begin
						hst_q <= dir ? dpbc_pkg::H_REL : dpbc_pkg::H_MEM;
					end
				end
				dpbc_pkg::H_REL: begin
					if (!i_portb_ack) begin
						hst_q <= dpbc_pkg::H_IDLE;
					end
				end
			endcase
		end
	end

	// Done flag: compare sets, high stop write clears, set wins
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			done_q <= 1'b0;
		end else if (hst_q == dpbc_pkg::H_IDLE && armed && match) begin
			done_q <= 1'b1;
		end else if (wr_go && adr_q == dpbc_pkg::A_HP_HI) begin
			done_q <= 1'b0;
		end
	end

	// ==========================================
	// Pointers
	assign inc_rp = (pa_q && !dir) || (host_inc && dir);
	assign inc_wp = (pa_q && dir) || (host_inc && !dir);

	always_ff @(posedge i_mclk) begin
		if (ptr_clr) begin
			rp_q <= dpbc_pkg::PTR_RST;
		end else if (wr_go && adr_q == dpbc_pkg::A_RP_LO) begin
			rp_q[7:0] <= i_ad;
		end else if (wr_go && adr_q == dpbc_pkg::A_RP_HI) begin
			rp_q[15:8] <= i_ad;
		end else if (inc_rp) begin
			rp_q <= ptr_inc(rp_q, size_q);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (ptr_clr) begin
			wp_q <= dpbc_pkg::PTR_RST;
		end else if (wr_go && adr_q == dpbc_pkg::A_WP_LO) begin
			wp_q[7:0] <= i_ad;
		end else if (wr_go && adr_q == dpbc_pkg::A_WP_HI) begin
			wp_q[15:8] <= i_ad;
		end else if (inc_wp) begin
			wp_q <= ptr_inc(wp_q, size_q);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (ptr_clr) begin
			hp_q <= dpbc_pkg::PTR_RST;
		end else if (wr_go && adr_q == dpbc_pkg::A_HP_LO) begin
			hp_q[7:0] <= i_ad;
		end else if (wr_go && adr_q == dpbc_pkg::A_HP_HI) begin
			hp_q[15:8] <= i_ad;
		end
	end

	// External latch refresh requests, set wins over service
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			upd_rp_q <= 1'b0;
			upd_wp_q <= 1'b0;
		end else begin
			if (mx && ((inc_rp && rp_q[7:0] == dpbc_pkg::LOW_MAX)
				|| (wr_go && adr_q == dpbc_pkg::A_RP_HI))) begin
				upd_rp_q <= 1'b1;
			end else if (upd_rp_go) begin
				upd_rp_q <= 1'b0;
			end
			if (mx && ((inc_wp && wp_q[7:0] == dpbc_pkg::LOW_MAX)
				|| (wr_go && adr_q == dpbc_pkg::A_WP_HI))) begin
				upd_wp_q <= 1'b1;
			end else if (upd_wp_go) begin
				upd_wp_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Arbitration and host bus pins
	dpbc_arb u_arb (
		.i_mclk(i_mclk),
		.i_rst(clr),
		.i_start(hic_q[dpbc_pkg::HIC_ARB]),
		.i_sel_in(i_sel_in),
		.i_bus_occupied_in(i_bus_occupied_in),
		.i_new_mode(mode_q[dpbc_pkg::MODE_ARB] ^ mode_q[dpbc_pkg::MODE_EXT]),
		.o_latched(),
		.o_bsy(arb_bsy)
	);

	// Software enables ORed with hardware enables
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			bsy_q <= 1'b0;
			boe_q <= 1'b0;
			bie_q <= 1'b0;
		end else begin
			bsy_q <= arb_bsy || hic_q[dpbc_pkg::HIC_BUS_OCCUPIED_OUT];
			boe_q <= arb_bsy || hw_boe || hic_q[dpbc_pkg::HIC_BOE];
			bie_q <= mem_d.bie || hic_q[dpbc_pkg::HIC_BIE];
		end
	end
	assign o_bus_occupied_out = bsy_q;
	assign o_sel_out = hic_q[dpbc_pkg::HIC_SEL_OUT];
	assign o_bus_out_enable_n = !boe_q;
	assign o_bus_in_enable_n = !bie_q;
endmodule
`default_nettype wire

// *** hw/dpbc_pkg.sv ***
package dpbc_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] A_HDATA = 8'h50;
	localparam logic [7:0] A_HDATA_HI = 8'h51;
	localparam logic [7:0] A_HIC = 8'h52;
	localparam logic [7:0] A_DMA = 8'h53;
	localparam logic [7:0] A_SIZE = 8'h54;
	localparam logic [7:0] A_MODE = 8'h55;
	localparam logic [7:0] A_RST = 8'h59;
	localparam logic [7:0] A_RP_LO = 8'h5A;
	localparam logic [7:0] A_RP_HI = 8'h5B;
	localparam logic [7:0] A_WP_LO = 8'h5C;
	localparam logic [7:0] A_WP_HI = 8'h5D;
	localparam logic [7:0] A_HP_LO = 8'h5E;
	localparam logic [7:0] A_HP_HI = 8'h5F;
	localparam logic [7:0] A_BUF = 8'h70;
	// ==========================================
	// Field positions
	localparam int HIC_ARB = 0;
	localparam int HIC_BIE = 2;
	localparam int HIC_BOE = 3;
	localparam int HIC_SEL_IN = 4;
	localparam int HIC_BUS_OCCUPIED_IN = 5;
	localparam int HIC_SEL_OUT = 6;
	localparam int HIC_BUS_OCCUPIED_OUT = 7;
	localparam int DMA_ACK = 1;
	localparam int DMA_WR_LATCH = 2;
	localparam int DMA_RD_LATCH = 3;
	localparam int DMA_DIR = 4;
	localparam int DMA_DONE = 5;
	localparam int DMA_EI = 6;
	localparam int DMA_ET = 7;
	localparam int MODE_EXT = 0;
	localparam int MODE_A14 = 1;
	localparam int MODE_A15 = 2;
	localparam int MODE_ARB = 3;
	localparam int MODE_MOE = 4;
	localparam int RST_BIT = 0;
	localparam int PIN_SHP = 8;
	localparam int PIN_SDP = 9;
	localparam int PIN_EI = 14;
	localparam int PIN_ET = 15;
	// ==========================================
	// Reset values and masks
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] HIC_WMASK = 8'hCD;
	localparam logic [7:0] DMA_WMASK = 8'hDC;
	localparam logic [7:0] LOW_MAX = 8'hFF;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [15:0] PTR_ONE = 16'h0001;
	localparam logic [7:0] RANGE_1K = 8'h03;
	localparam logic [7:0] RANGE_16K = 8'h3F;
	localparam logic [7:0] RANGE_32K = 8'h7F;
	localparam logic [7:0] RANGE_64K = 8'hFF;
	// ==========================================
	// Arbitration timing in clocks
	localparam logic [2:0] ARB_SET_CYC = 3'h2;
	localparam logic [2:0] ARB_BSY_CYC = 3'h4;
	// ==========================================
	// Types
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_MEM = 2'b01,
		H_REQ = 2'b10,
		H_REL = 2'b11
	} dpbc_host_e;
	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00,
		ARB_WAIT = 2'b01,
		ARB_SETTLE = 2'b10,
		ARB_WON = 2'b11
	} dpbc_arb_e;
	typedef struct packed {
		logic [15:0] addr;
		logic sel_n;
		logic we_n;
		logic lo;
		logic bie;
	} dpbc_mem_s;
endpackage

// *** hw/dpbc_arb.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpbc_arb (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_sel_in,
	input wire logic i_bus_occupied_in,
	input wire logic i_new_mode,
	output logic o_latched,
	output logic o_bsy
);
	// ==========================================
	// Arbitration sequencer
	dpbc_pkg::dpbc_arb_e st_q;
	logic [2:0] cnt_q;

	// Wait for free bus, settle, then latch
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_start) begin
			st_q <= dpbc_pkg::ARB_IDLE;
			cnt_q <= 3'h0;
		end else begin
			unique case (st_q)
				dpbc_pkg::ARB_IDLE: begin
					st_q <= dpbc_pkg::ARB_WAIT;
				end
				dpbc_pkg::ARB_WAIT: begin
					cnt_q <= 3'h0;
					if (!i_sel_in && !i_bus_occupied_in) begin
						st_q <= dpbc_pkg::ARB_SETTLE;
					end
				end
				dpbc_pkg::ARB_SETTLE: begin
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == dpbc_pkg::ARB_SET_CYC - 3'h1) begin
						st_q <= dpbc_pkg::ARB_WON;
						cnt_q <= 3'h0;
					end
				end
				dpbc_pkg::ARB_WON: begin
					if (i_sel_in && !o_bsy) begin
						st_q <= dpbc_pkg::ARB_WAIT; // Select resets the latch while busy is not yet asserted
					end else if (cnt_q != dpbc_pkg::ARB_BSY_CYC) begin
						cnt_q <= cnt_q + 3'h1;
					end
				end
			endcase
		end
	end

	// Busy follows latch at once or after a guard time
	assign o_latched = (st_q == dpbc_pkg::ARB_WON);
	assign o_bsy = o_latched && (!i_new_mode || cnt_q == dpbc_pkg::ARB_BSY_CYC);
endmodule
`default_nettype wire

// *** dv/dpbc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Host DMA side: acknowledge after a chosen delay
module dpbc_host_model (
	input wire logic i_mclk,
	input wire logic i_req,
	input wire logic [3:0] i_delay,
	output logic o_ack
);
	logic [3:0] wait_q;
	// Raise after the delay, hold until request drops
	always_ff @(posedge i_mclk) begin
		if (!i_req) begin
			o_ack <= 1'b0;
			wait_q <= 4'h0;
		end else if (!o_ack) begin
			if (wait_q >= i_delay) o_ack <= 1'b1;
			else wait_q <= wait_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** dv/dpbc_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port watch
module dpbc_checker (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_cs,
	input wire logic i_ale,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_ad,
	input wire logic [7:0] o_ad,
	input wire logic o_ad_oe_n,
	input wire logic i_porta_req_n,
	input wire logic o_portb_req,
	input wire logic i_portb_ack,
	input wire logic i_sel_in,
	input wire logic i_bus_occupied_in,
	input wire logic o_sel_out,
	input wire logic o_bus_occupied_out,
	input wire logic [15:0] o_addr,
	input wire logic o_memory_select_n,
	input wire logic o_we_n,
	input wire logic o_bus_in_enable_n,
	input wire logic o_bus_out_enable_n,
	input wire logic o_latch_out
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Outputs idle right after reset
	a_reset_idle: assert property ($fell(i_rst) |-> (o_addr == 16'hC000) &&
		!o_portb_req && !o_latch_out && o_we_n && o_memory_select_n)
		else $error("outputs busy after reset");
	// Peripheral cycle two edges after request, no host latch then
	a_porta_first: assert property (!i_porta_req_n |-> ##2 (!o_memory_select_n && !o_latch_out))
		else $error("peripheral cycle missing");
	// Handshake
	a_ack_drop: assert property (o_portb_req && i_portb_ack |=> !o_portb_req)
		else $error("request kept after acknowledge");
	a_req_hold: assert property (o_portb_req && !i_portb_ack |=> o_portb_req)
		else $error("request dropped early");
	// Latch strobe, read drive and arbitration
	a_lo_pulse: assert property (o_latch_out |=> !o_latch_out)
		else $error("latch pulse too long");
	a_lo_read: assert property (o_latch_out |-> o_we_n)
		else $error("latch during write");
	a_oe_read: assert property (!o_ad_oe_n |-> i_cs && !i_rd_n)
		else $error("data driven without read");
	a_arb_free: assert property ($rose(o_bus_occupied_out) && $fell(o_bus_out_enable_n) |->
		$past(!i_sel_in && !i_bus_occupied_in, 3)) else $error("busy won on occupied bus");
	// Main scenarios
	c_porta: cover property (!i_porta_req_n ##2 !o_memory_select_n);
	c_hand: cover property (o_portb_req && i_portb_ack);
	c_arb: cover property ($rose(o_bus_occupied_out));
endmodule
bind dpbc_top dpbc_checker chk (.*);
`default_nettype wire

// *** dv/dual_port_ring_buffer_ctrl_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module dual_port_ring_buffer_ctrl_bench;
	logic i_mclk, i_rst, i_cs, i_ale, i_rd_n, i_wr_n, i_porta_req_n, i_sel_in, i_bus_occupied_in;
	logic [7:0] i_ad;
	wire logic i_portb_ack;
	logic [7:0] o_ad;
	logic o_ad_oe_n, o_portb_req, o_sel_out, o_bus_occupied_out, o_memory_select_n, o_we_n;
	logic o_bus_in_enable_n, o_bus_out_enable_n, o_latch_out;
	logic [15:0] o_addr;
	logic [3:0] ack_delay;
	logic ack_q, mux_on;
	logic [7:0] strobe_hp;
	int fails, num_checks, cycles, lo_cnt, ack_cnt;
	logic [7:0] mode_t[3] = '{8'h07, 8'h03, 8'h01};
	logic [7:0] size_t[3] = '{8'hFF, 8'h7F, 8'h3F};
	logic [15:0] addr_t[3] = '{16'h00FF, 16'h80FF, 16'hC0FF};
	dpbc_top uut (.*);
	dpbc_host_model host (.i_mclk(i_mclk), .i_req(o_portb_req), .i_delay(ack_delay),
		.o_ack(i_portb_ack));
	// ==========================================
	// Clock, monitor and timeout
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		ack_q <= i_portb_ack;
		if (o_latch_out === 1'b1) lo_cnt++;
		if (i_portb_ack === 1'b1 && ack_q !== 1'b1) ack_cnt++;
		if (mux_on && o_addr[8] === 1'b1) strobe_hp = o_addr[7:0];
		cycles++;
		if (cycles > 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	// ==========================================
	// Tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_ale <= 1'b1;
		i_ad <= a;
		@(posedge i_mclk);
		i_ale <= 1'b0;
		i_cs <= 1'b1;
		i_wr_n <= 1'b0;
		i_ad <= d;
		@(posedge i_mclk);
		i_wr_n <= 1'b1;
		i_cs <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		i_ale <= 1'b1;
		i_ad <= a;
		@(posedge i_mclk);
		i_ale <= 1'b0;
		i_cs <= 1'b1;
		i_rd_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		#1 d = o_ad;
		@(posedge i_mclk);
		i_rd_n <= 1'b1;
		i_cs <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e, "register read");
	endtask
	// One request, kept two clocks apart from the next
	task automatic pa(input logic [15:0] ea, input logic ewe);
		@(posedge i_mclk);
		i_porta_req_n <= 1'b0;
		@(posedge i_mclk);
		i_porta_req_n <= 1'b1;
		@(posedge i_mclk);
		#1 chk(o_addr, ea, "port A address");
		chk(o_memory_select_n, 1'b0, "port A select");
		chk(o_we_n, ewe, "port A write enable");
	endtask
	task automatic wait_done();
		logic [7:0] d;
		d = 8'h00;
		for (int n = 0; n < 50 && d[dpbc_pkg::DMA_DONE] !== 1'b1; n++) rd(8'h53, d);
		chk(d[dpbc_pkg::DMA_DONE], 1'b1, "done flag");
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{i_rst, i_cs, i_ale, i_rd_n, i_wr_n} = 5'b10011;
		{i_porta_req_n, i_sel_in, i_bus_occupied_in, mux_on} = 4'b1000;
		i_ad = 8'h00;
		ack_delay = 4'h0;
		{fails, num_checks, cycles, lo_cnt, ack_cnt} = '0;
		repeat (10) @(posedge i_mclk);
		i_rst <= 1'b0;
		wr(8'h59, 8'h00);
		for (int a = 8'h5A; a <= 8'h5F; a++) rc(8'(a), 8'h00);
		rc(8'h54, 8'h00);
		rc(8'h56, 8'h00);
		wr(8'h5C, 8'h34);
		rc(8'h5C, 8'h34);
		wr(8'h59, 8'h00);
		rc(8'h5C, 8'h00);
		// Direct ranges and peripheral writes into the buffer
		wr(8'h53, 8'h10);
		for (int k = 0; k < 3; k++) begin
			wr(8'h55, mode_t[k]);
			wr(8'h54, size_t[k]);
			wr(8'h5C, 8'hFF);
			wr(8'h5D, 8'h00);
			pa(addr_t[k], 1'b0);
		end
		rc(8'h5D, 8'h01);
		// Ring wrap at 512 bytes, read toward the peripheral
		wr(8'h53, 8'h00);
		wr(8'h55, 8'h00);
		wr(8'h54, 8'h01);
		wr(8'h5A, 8'hFF);
		wr(8'h5B, 8'h01);
		pa(16'hC1FF, 1'b1);
		rc(8'h5B, 8'h00);
		// Processor buffer access and host data latch
		wr(8'h53, 8'h10);
		wr(8'h5C, 8'h42);
		wr(8'h70, 8'hA5);
		rc(8'h5C, 8'h42);
		lo_cnt = 0;
		wr(8'h50, 8'h11);
		repeat (3) @(posedge i_mclk);
		chk(16'(lo_cnt), 16'h0001, "latch pulses");
		// Buffer to host, halt at stop, resume on new stop
		wr(8'h54, 8'h00);
		wr(8'h59, 8'h00);
		wr(8'h5E, 8'h03);
		{ack_cnt, lo_cnt} = '0;
		wr(8'h53, 8'h18);
		wait_done();
		rc(8'h5A, 8'h03);
		chk(16'(ack_cnt), 16'h0003, "handshakes");
		chk(16'(lo_cnt), 16'h0003, "data latches");
		ack_delay <= 4'h3;
		wr(8'h5E, 8'h05);
		wr(8'h5F, 8'h00);
		pa(16'hC000, 1'b0);
		wait_done();
		rc(8'h5A, 8'h05);
		// Host to buffer
		wr(8'h53, 8'h00);
		wr(8'h59, 8'h00);
		wr(8'h5E, 8'h02);
		wr(8'h5F, 8'h00);
		wr(8'h53, 8'h04);
		wait_done();
		rc(8'h5C, 8'h02);
		wr(8'h53, 8'h00);
		// Multiplexed addressing when size exceeds 1K direct
		wr(8'h54, 8'h0F);
		strobe_hp = 8'h00;
		mux_on = 1'b1;
		wr(8'h5B, 8'h05);
		wr(8'h5B, 8'h05);
		repeat (3) @(posedge i_mclk);
		chk(strobe_hp, 8'h05, "latch load");
		wr(8'h5A, 8'hFF);
		@(posedge i_mclk);
		i_porta_req_n <= 1'b0;
		@(posedge i_mclk);
		i_porta_req_n <= 1'b1;
		repeat (6) @(posedge i_mclk);
		chk(strobe_hp, 8'h06, "latch refresh");
		mux_on = 1'b0;
		// Arbitration held off while the bus is occupied
		{i_sel_in, i_bus_occupied_in} <= 2'b11;
		wr(8'h52, 8'h01);
		repeat (6) @(posedge i_mclk);
		chk(o_bus_occupied_out, 1'b0, "busy held off");
		rc(8'h52, 8'h30);
		{i_sel_in, i_bus_occupied_in} <= 2'b00;
		repeat (5) @(posedge i_mclk);
		#1 chk(o_bus_occupied_out, 1'b1, "busy won");
		chk(o_bus_out_enable_n, 1'b0, "bus out on win");
		rc(8'h52, 8'h01);
		wr(8'h52, 8'h00);
		repeat (2) @(posedge i_mclk);
		#1 chk(o_bus_occupied_out, 1'b0, "busy cleared");
		// New arbitration scheme: busy waits out the guard time after the latch
		wr(8'h55, 8'h08);
		wr(8'h52, 8'h01);
		repeat (8) @(posedge i_mclk);
		#1 chk(o_bus_occupied_out, 1'b0, "busy guard time");
		@(posedge i_mclk);
		#1 chk(o_bus_occupied_out, 1'b1, "busy after guard");
		chk(o_bus_out_enable_n, 1'b0, "bus out after guard");
		wr(8'h52, 8'h00);
		repeat (2) @(posedge i_mclk);
		wr(8'h52, 8'hC0);
		repeat (2) @(posedge i_mclk);
		#1 chk({o_sel_out, o_bus_occupied_out}, 2'b11, "driven outputs");
		wr(8'h52, 8'h0C);
		repeat (2) @(posedge i_mclk);
		#1 chk({o_bus_in_enable_n, o_bus_out_enable_n}, 2'b00, "software enables");
		wr(8'h52, 8'h00);
		// Second reset in mid-run
		i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		rc(8'h5C, 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
